//--- verilog/pis_map.svh
// offsets, codes, field positions and timing counts of the process input sequencer
`ifndef PIS_MAP_SVH
`define PIS_MAP_SVH

// instruction classes carried in the command kind field
`define PIS_KIND_OUT_ACC 2'h0
`define PIS_KIND_CTRL_PULSE 2'h1
`define PIS_KIND_SKIP_STAT 2'h2
`define PIS_KIND_IN_ACC 2'h3

// function and device code, ten bits
`define PIS_DEV_ADDR 6'h13
`define PIS_CODE_LVL_SEL 10'h053
`define PIS_CODE_POINT 10'h0d3
`define PIS_CODE_XFER 10'h1d3
`define PIS_CODE_ANALOG 10'h09b
`define PIS_CODE_ALARM 10'h11b
`define PIS_CODE_COUNTER 10'h15b
`define PIS_CODE_IN_CLR 10'h213
`define PIS_CODE_IN_OR 10'h013

// accumulator fields, bit 16 of the processor is bit 0 here
`define PIS_LVL_PATTERN 9'h10b
`define PIS_LVL_HIGH 3'h1
`define PIS_LVL_LOW 3'h2
`define PIS_XFER_ANALOG_PAT 12'h480
`define PIS_XFER_DIGITAL_TAG 3'h4
`define PIS_RACK_ONE 3'h1
`define PIS_RACK_TWO 3'h2
`define PIS_UPPER_LAST 6'h17
`define PIS_LOWER_FIRST 6'h20
`define PIS_LOWER_LAST 6'h37
`define PIS_LOWER_OFFSET 6'h08
`define PIS_RACK_PAIRS 7'h30
`define PIS_SPECIAL_PAIRS 6'h10

// card kinds on the strap inputs
`define PIS_CARD_LEVEL 2'h0
`define PIS_CARD_ALARM 2'h1
`define PIS_CARD_COUNTER 2'h2

`define PIS_CNT_WIDTH 6

// timing
`define PIS_CLK_NS 20
`define PIS_CYCLE_TIME_NS 960
`define PIS_LVL_BUSY_CYC (2 * `PIS_CYCLE_TIME_NS / `PIS_CLK_NS)
`define PIS_POINT_BUSY_CYC (11 * `PIS_CYCLE_TIME_NS / `PIS_CLK_NS)
`define PIS_XFER_BUSY_CYC (7 * `PIS_CYCLE_TIME_NS / `PIS_CLK_NS)
`define PIS_DIG_BUSY_CYC (15 * `PIS_CYCLE_TIME_NS / `PIS_CLK_NS)
`define PIS_BUSY_W 10
`define PIS_CONV_MS 5
`define PIS_CONV_CYC (`PIS_CONV_MS * 1000000 / `PIS_CLK_NS)
`define PIS_CONV_W 18

`endif

//--- verilog/pis_pkg.sv
// types shared by the process input sequencer
`default_nettype none
package pis_pkg;

    typedef struct packed {
        logic [1:0] kind;
        logic [3:0] func;
        logic [5:0] dev;
    } pis_cmd_t;

    typedef enum logic {
        PIS_ADC_IDLE,
        PIS_ADC_CONV
    } pis_adc_state_t;

endpackage
`default_nettype wire

//--- verilog/pis_counter.sv
// one counter-input card: edge counter with clear and half-full pulse
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.svh"
module pis_counter #(
    parameter int WIDTH = `PIS_CNT_WIDTH
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic level_i,
    input wire logic clear_i,
    output logic [WIDTH-1:0] count_o,
    output logic half_o
);
    logic level_q;
    logic rise;
    localparam logic [WIDTH-1:0] HALF_LESS_ONE = WIDTH'((1 << (WIDTH - 1)) - 1);

    assign rise = en_i & level_i & ~level_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_i;
        end
    end

    // count and clear
    // a closure landing on the clear cycle is kept, not lost
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_o <= '0;
        end else if (!en_i) begin
            count_o <= '0;
        end else if (clear_i) begin
            count_o <= rise ? WIDTH'(1) : '0;
        end else if (rise) begin
            count_o <= count_o + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            half_o <= 1'b0;
        end else begin
            half_o <= rise & ~clear_i & (count_o == HALF_LESS_ONE);
        end
    end

endmodule
`default_nettype wire

//--- verilog/pis_sequencer.sv
// process input sequencer: analog conversion control and digital input card pairs
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.svh"

// Overview of operation
// - level select holds busy at most two cycle times
// - point address is forwarded only after some earlier level select with a valid level field
// - point address holds busy at most eleven cycle times; conversion starts with the command
// - conversion lasts about five milliseconds and then requests an interrupt
// - analog status test skips when no analog request is pending; acknowledge clears the analog request
// - result transfer needs pattern 2200 and holds busy seven cycle times
// - transferring the result leaves the converter result register unchanged
// - clearing read returns the result in bits one to fourteen
// - non-clearing read ORs transferred data into the accumulator
// - reads complete with no busy interval afterwards
// - card pairs decode at 00-27 upper nest and 40-67 lower nest
// - counters and alarms exist only at pairs 00-17 of rack one
// - accumulator bits five to sixteen map to six terminals per card
// - level inputs are sampled on transfer and raise no interrupt
// - any alarm input change raises an interrupt
// - six-bit counters clear automatically after their value is transferred
// - a counter reaching thirty-two raises an interrupt
// - alarm and counter requests have own status tests and acknowledges
module pis_sequencer
    import pis_pkg::*;
#(
    parameter int CONV_CYCLES = `PIS_CONV_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire pis_cmd_t addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rd_data_o,
    output logic busy_o,
    output logic irq_o,
    output logic [2:0] level_sel_o,
    output logic [11:0] point_addr_o,
    output logic conv_active_o,
    input wire logic [13:0] adc_value_i,
    input wire logic [95:0][11:0] din_i,
    input wire logic [31:0][1:0] card_kind_i
);
    logic [`PIS_BUSY_W-1:0] busy_cnt;
    logic [`PIS_BUSY_W-1:0] next_busy;
    logic accept;
    logic [9:0] code;
    logic is_out;
    logic is_pulse;
    logic is_skip;
    logic is_in;
    logic do_lvl;
    logic do_point;
    logic do_xfer;
    logic xfer_analog;
    logic xfer_digital;
    logic do_in_clr;
    logic do_in_or;
    logic dev_touch;
    logic lvl_ok;
    logic level_seen;
    pis_adc_state_t adc_state;
    logic [`PIS_CONV_W-1:0] conv_cnt;
    logic conv_done;
    logic [13:0] adc_s1;
    logic [13:0] adc_s2;
    logic [13:0] adc_result;
    logic [95:0][11:0] din_s1;
    logic [95:0][11:0] din_s2;
    logic [31:0][1:0] kind_s1;
    logic [31:0][1:0] kind_s2;
    logic [15:0][11:0] alarm_q;
    logic pend_analog;
    logic pend_alarm;
    logic pend_counter;
    logic [15:0] xfer_data;
    logic xfer_valid;
    logic [2:0] dig_rack;
    logic [5:0] dig_zz;
    logic [5:0] nest_idx;
    logic [6:0] pair_idx;
    logic dig_ok;
    logic cnt_zone;
    logic [11:0] dig_data;
    logic [31:0] cnt_clear;
    logic [31:0][`PIS_CNT_WIDTH-1:0] cnt_val;
    logic [31:0] cnt_half;
    logic [31:0] alarm_chg;

    // commands only while idle
    // a command during busy is dropped, not queued
    assign accept = (wr_i | rd_i) & (busy_cnt == '0);
    assign busy_o = (busy_cnt != '0);
    assign code = {addr_i.func, addr_i.dev};
    assign is_out = accept & wr_i & (addr_i.kind == `PIS_KIND_OUT_ACC);
    assign is_pulse = accept & wr_i & (addr_i.kind == `PIS_KIND_CTRL_PULSE);
    assign is_skip = accept & rd_i & (addr_i.kind == `PIS_KIND_SKIP_STAT);
    assign is_in = accept & rd_i & (addr_i.kind == `PIS_KIND_IN_ACC);
    assign do_lvl = is_out & (code == `PIS_CODE_LVL_SEL);
    assign do_point = is_out & (code == `PIS_CODE_POINT);
    assign do_xfer = is_out & (code == `PIS_CODE_XFER);
    assign xfer_analog = do_xfer & (wr_data_i[11:0] == `PIS_XFER_ANALOG_PAT);
    // a bad rack or pair gives no busy and latches nothing
    assign xfer_digital = do_xfer & (wr_data_i[11:9] == `PIS_XFER_DIGITAL_TAG) & dig_ok;
    assign do_in_clr = is_in & (code == `PIS_CODE_IN_CLR);
    assign do_in_or = is_in & (code == `PIS_CODE_IN_OR);
    assign dev_touch = accept & (addr_i.dev == `PIS_DEV_ADDR);
    assign lvl_ok = (wr_data_i[11:3] == `PIS_LVL_PATTERN)
        & ((wr_data_i[2:0] == `PIS_LVL_HIGH) | (wr_data_i[2:0] == `PIS_LVL_LOW));
    assign irq_o = pend_analog | pend_alarm | pend_counter;
    assign conv_active_o = (adc_state == PIS_ADC_CONV);

    always_comb begin
        next_busy = '0;
        if (do_lvl) begin
            next_busy = `PIS_BUSY_W'(`PIS_LVL_BUSY_CYC);
        end else if (do_point) begin
            next_busy = `PIS_BUSY_W'(`PIS_POINT_BUSY_CYC);
        end else if (xfer_analog) begin
            next_busy = `PIS_BUSY_W'(`PIS_XFER_BUSY_CYC);
        end else if (xfer_digital) begin
            next_busy = `PIS_BUSY_W'(`PIS_DIG_BUSY_CYC);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_cnt <= '0;
        end else if (busy_cnt != '0) begin
            busy_cnt <= busy_cnt - `PIS_BUSY_W'(1);
        end else begin
            busy_cnt <= next_busy;
        end
    end

    // level select and its memory
    // a bad level field still costs the busy interval
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_sel_o <= '0;
            level_seen <= 1'b0;
        end else if (do_lvl && lvl_ok) begin
            level_sel_o <= wr_data_i[2:0];
            level_seen <= 1'b1;
        end
    end

    // converter value comes off pins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            adc_s1 <= '0;
            adc_s2 <= '0;
            din_s1 <= '0;
            din_s2 <= '0;
            alarm_q <= '0;
        end else begin
            adc_s1 <= adc_value_i;
            adc_s2 <= adc_s1;
            din_s1 <= din_i;
            din_s2 <= din_s1;
            alarm_q <= din_s2[15:0];
        end
    end

    // straps are pins too, so they pass the same two flops
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            kind_s1 <= '0;
            kind_s2 <= '0;
        end else begin
            kind_s1 <= card_kind_i;
            kind_s2 <= kind_s1;
        end
    end

    // a point address during conversion is not started
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            adc_state <= PIS_ADC_IDLE;
            conv_cnt <= '0;
            point_addr_o <= '0;
        end else begin
            unique case (adc_state)
                PIS_ADC_IDLE: begin
                    if (do_point && level_seen) begin
                        point_addr_o <= wr_data_i[11:0];
                        conv_cnt <= `PIS_CONV_W'(CONV_CYCLES - 1);
                        adc_state <= PIS_ADC_CONV;
                    end
                end
                PIS_ADC_CONV: begin
                    if (conv_cnt == '0) begin
                        adc_state <= PIS_ADC_IDLE;
                    end else begin
                        conv_cnt <= conv_cnt - `PIS_CONV_W'(1);
                    end
                end
            endcase
        end
    end

    // the request rises on the edge at which the converter goes idle
    assign conv_done = (adc_state == PIS_ADC_CONV) && (conv_cnt == '0);

    // result held until the next conversion ends
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            adc_result <= '0;
        end else if (conv_done) begin
            adc_result <= adc_s2;
        end
    end

    always_comb begin
        dig_rack = wr_data_i[8:6];
        dig_zz = wr_data_i[5:0];
        dig_ok = ((dig_rack == `PIS_RACK_ONE) | (dig_rack == `PIS_RACK_TWO))
            & ((dig_zz <= `PIS_UPPER_LAST)
            | ((dig_zz >= `PIS_LOWER_FIRST) & (dig_zz <= `PIS_LOWER_LAST)));
        nest_idx = dig_zz[5] ? (dig_zz - `PIS_LOWER_OFFSET) : dig_zz;
        pair_idx = {1'b0, nest_idx} + ((dig_rack == `PIS_RACK_TWO) ? `PIS_RACK_PAIRS : 7'h00);
        cnt_zone = (dig_rack == `PIS_RACK_ONE) & (dig_zz < `PIS_SPECIAL_PAIRS);
    end

    // six bits per card, counters replace terminal data
    always_comb begin
        dig_data = dig_ok ? din_s2[pair_idx] : '0;
        cnt_clear = '0;
        if (cnt_zone && kind_s2[{dig_zz[3:0], 1'b0}] == `PIS_CARD_COUNTER) begin
            dig_data[11:6] = cnt_val[{dig_zz[3:0], 1'b0}];
            cnt_clear[{dig_zz[3:0], 1'b0}] = xfer_digital;
        end
        if (cnt_zone && kind_s2[{dig_zz[3:0], 1'b1}] == `PIS_CARD_COUNTER) begin
            dig_data[5:0] = cnt_val[{dig_zz[3:0], 1'b1}];
            cnt_clear[{dig_zz[3:0], 1'b1}] = xfer_digital;
        end
    end

    // counter and alarm cards, upper file then lower file of each pair
    for (genvar c = 0; c < 32; c++) begin : g_card
        localparam int HI = (c % 2 == 0) ? 11 : 5;
        logic [5:0] live;
        logic [5:0] prev;
        assign live = din_s2[c / 2][HI -: 6];
        assign prev = alarm_q[c / 2][HI -: 6];
        assign alarm_chg[c] = (kind_s2[c] == `PIS_CARD_ALARM) & (live != prev);
        // counter on one terminal, live bit 5
        pis_counter #(
            .WIDTH(`PIS_CNT_WIDTH)
        ) u_counter (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .en_i(kind_s2[c] == `PIS_CARD_COUNTER),
            .level_i(live[5]),
            .clear_i(cnt_clear[c]),
            .count_o(cnt_val[c]),
            .half_o(cnt_half[c])
        );
    end

    // analog request: a set in the acknowledge cycle wins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_analog <= 1'b0;
        end else begin
            pend_analog <= conv_done
                | (pend_analog & ~(is_pulse & (code == `PIS_CODE_ANALOG)));
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_alarm <= 1'b0;
        end else begin
            pend_alarm <= (|alarm_chg)
                | (pend_alarm & ~(is_pulse & (code == `PIS_CODE_ALARM)));
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_counter <= 1'b0;
        end else begin
            pend_counter <= (|cnt_half)
                | (pend_counter & ~(is_pulse & (code == `PIS_CODE_COUNTER)));
        end
    end

    // adapter holding word
    // any other instruction with device code PIS_DEV_ADDR in between discards it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xfer_data <= '0;
            xfer_valid <= 1'b0;
        end else if (xfer_analog) begin
            xfer_data <= {adc_result, 2'b00};
            xfer_valid <= 1'b1;
        end else if (xfer_digital) begin
            xfer_data <= {4'h0, dig_data};
            xfer_valid <= 1'b1;
        end else if (dev_touch) begin
            xfer_valid <= 1'b0;
        end
    end

    // read answers, one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= '0;
            if (do_in_clr) begin
                rd_data_o <= xfer_valid ? xfer_data : '0;
            end else if (do_in_or) begin
                rd_data_o <= wr_data_i | (xfer_valid ? xfer_data : 16'h0000);
            end else if (is_skip && code == `PIS_CODE_ANALOG) begin
                rd_data_o <= {15'h0000, ~pend_analog};
            end else if (is_skip && code == `PIS_CODE_ALARM) begin
                rd_data_o <= {15'h0000, ~pend_alarm};
            end else if (is_skip && code == `PIS_CODE_COUNTER) begin
                rd_data_o <= {15'h0000, ~pend_counter};
            end
        end
    end

endmodule
`default_nettype wire

//--- verification/pis_field_model.sv
// field-side model: converter value and digital terminal pins
`timescale 1ns/1ps
`default_nettype none
module pis_field_model (
    input wire logic [11:0] point_i,
    input wire logic pulse_i,
    input wire logic [5:0] alarm_i,
    input wire logic [5:0] lvl_i,
    output logic [13:0] adc_o,
    output logic [95:0][11:0] din_o,
    output logic [31:0][1:0] kind_o
);
    always_comb begin
        case (point_i)
            12'h000: adc_o = 14'h1fff;
            12'h001: adc_o = 14'h2001;
            default: adc_o = 14'(point_i);
        endcase
    end
    // counter pair 00, alarm pair 01
    assign kind_o = 64'h12;
    // pattern from the low six bits of the pair number, so a wrong decode reads another pattern unless it lands 64 pairs off
    always_comb begin
        for (int i = 0; i < 96; i++) begin
            din_o[i] = {6'(i), ~6'(i)};
        end
        din_o[0][11] = pulse_i;
        din_o[1][11:6] = alarm_i;
        din_o[2][5:0] = lvl_i;
    end
endmodule
`default_nettype wire

//--- verification/pis_sequencer_chk.sv
// checker for the process input sequencer command port
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.svh"
module pis_chk
    import pis_pkg::*;
#(
    parameter int CONV_CYCLES = `PIS_CONV_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire pis_cmd_t addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rd_data_o,
    input wire logic busy_o,
    input wire logic irq_o,
    input wire logic [2:0] level_sel_o,
    input wire logic [11:0] point_addr_o,
    input wire logic conv_active_o,
    input wire logic [13:0] adc_value_i,
    input wire logic [95:0][11:0] din_i,
    input wire logic [31:0][1:0] card_kind_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic go;
    logic pt_go;
    logic [9:0] run;
    logic [9:0] want;
    assign go = wr_i && !busy_o;
    assign pt_go = go && addr_i == {2'h0, `PIS_CODE_POINT};
    // ten bits hold the longest hold of 720 cycles
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run <= '0;
        end else if (go) begin
            run <= '0;
        end else if (busy_o) begin
            run <= run + 10'h1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            want <= '0;
        end else if (go) begin
            case ({addr_i.func, addr_i.dev})
                `PIS_CODE_LVL_SEL: want <= 10'h060;
                `PIS_CODE_POINT: want <= 10'h210;
                default: want <= (wr_data_i[11:0] == `PIS_XFER_ANALOG_PAT) ? 10'h150 : 10'h2d0;
            endcase
        end
    end
    sequence lvl_go;
        go && addr_i == {2'h0, `PIS_CODE_LVL_SEL};
    endsequence
    property ack_skip(logic [9:0] c);
        (go && addr_i == {2'h1, c}) ##2 (rd_i && !busy_o && addr_i == {2'h2, c}) |=> rd_data_o[0];
    endproperty
    lvl_busy_a: assert property (lvl_go |=> busy_o[*8] ##88 busy_o ##1 !busy_o)
        else $error("level select hold wrong");
    busy_len_a: assert property ($fell(busy_o) |-> run == want)
        else $error("busy length wrong");
    busy_cause_a: assert property (!go && !busy_o |=> !busy_o)
        else $error("busy without command");
    rd_idle_a: assert property (!(rd_i && !busy_o) |=> rd_data_o == 16'h0)
        else $error("read data outside read");
    conv_irq_a: assert property ($fell(conv_active_o) |-> ##[0:2] irq_o)
        else $error("no request after conversion");
    no_level_a: assert property (pt_go && level_sel_o == 3'h0 |=> !conv_active_o)
        else $error("conversion without level");
    conv_start_a: assert property (pt_go && level_sel_o != 3'h0 && !conv_active_o
        |=> point_addr_o == $past(wr_data_i[11:0]) ##[0:1] conv_active_o) else $error("no start");
    point_hold_a: assert property (pt_go && conv_active_o |=> $stable(point_addr_o))
        else $error("point changed in conversion");
    lvl_store_a: assert property (lvl_go ##1 $past(wr_data_i[11:0]) == 12'h85a |-> level_sel_o == 3'h2)
        else $error("low level not stored");
    ack_an_a: assert property (ack_skip(`PIS_CODE_ANALOG))
        else $error("analog request not cleared");
    ack_cnt_a: assert property (ack_skip(`PIS_CODE_COUNTER))
        else $error("counter request not cleared");
endmodule
bind pis_sequencer pis_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .busy_o(busy_o), .irq_o(irq_o), .level_sel_o(level_sel_o), .point_addr_o(point_addr_o),
    .conv_active_o(conv_active_o), .adc_value_i(adc_value_i), .din_i(din_i),
    .card_kind_i(card_kind_i));
`default_nettype wire

//--- verification/pis_sequencer_bench.sv
// self-checking bench for the process input sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.svh"
module pis_sequencer_bench
    import pis_pkg::*;
;
    localparam int CV = 700;
    localparam logic [11:0] LV = {2'h0, `PIS_CODE_LVL_SEL};
    localparam logic [11:0] PT = {2'h0, `PIS_CODE_POINT};
    localparam logic [11:0] XF = {2'h0, `PIS_CODE_XFER};
    localparam logic [11:0] RC = {2'h3, `PIS_CODE_IN_CLR};
    localparam logic [11:0] RO = {2'h3, `PIS_CODE_IN_OR};
    localparam logic [11:0] SA = {2'h2, `PIS_CODE_ANALOG};
    localparam logic [11:0] AA = {2'h1, `PIS_CODE_ANALOG};
    localparam logic [11:0] SC = {2'h2, `PIS_CODE_COUNTER};
    localparam logic [11:0] AC = {2'h1, `PIS_CODE_COUNTER};
    localparam logic [11:0] SL = {2'h2, `PIS_CODE_ALARM};
    localparam logic [11:0] AL = {2'h1, `PIS_CODE_ALARM};
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    pis_cmd_t addr_i = '0;
    logic [15:0] wr_data_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic pulse = 1'b0;
    logic [5:0] alarm = '0;
    logic [5:0] lvl = 6'h15;
    logic [15:0] rd_data_o;
    logic [15:0] q;
    logic busy_o, irq_o, conv_active_o;
    logic [2:0] level_sel_o;
    logic [11:0] point_addr_o;
    logic [13:0] adc;
    logic [95:0][11:0] din;
    logic [31:0][1:0] kinds;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int t0;
    always #10 clk_i = ~clk_i;
    pis_sequencer #(.CONV_CYCLES(CV)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .busy_o(busy_o),
        .irq_o(irq_o), .level_sel_o(level_sel_o), .point_addr_o(point_addr_o),
        .conv_active_o(conv_active_o), .adc_value_i(adc), .din_i(din), .card_kind_i(kinds));
    pis_field_model model (.point_i(point_addr_o), .pulse_i(pulse), .alarm_i(alarm), .lvl_i(lvl),
        .adc_o(adc), .din_o(din), .kind_o(kinds));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // waits out busy unless now is set, so a refused command can be aimed into it
    task automatic cmd(input logic [11:0] a, input logic [15:0] d, input bit now = 1'b0);
        for (int n = 0; n < 2000 && !now && busy_o !== 1'b0; n++) wt(1);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= !a[11];
        rd_i <= a[11];
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
        q = rd_data_o;
    endtask
    task automatic bl(input int e);
        int n;
        n = 0;
        while (busy_o === 1'b1 && n < 1000) begin
            wt(1);
            n++;
        end
        chk("busy cycles", 16'(n), 16'(e));
    endtask
    task automatic fetch(input logic [15:0] e);
        cmd(XF, 16'h0480);
        bl(336);
        cmd(RC, 16'h0);
        chk("analog", q, e);
    endtask
    task automatic dx(input logic [15:0] a, input logic [15:0] e);
        cmd(XF, a);
        cmd(RC, 16'h0);
        chk("digital", q, e);
    endtask
    task automatic pl(input int n);
        repeat (n) begin
            @(posedge clk_i) pulse <= 1'b1;
            repeat (2) @(posedge clk_i);
            pulse <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        wt(4);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk("read data", rd_data_o, 16'h0);
        chk("flags", {10'h0, busy_o, irq_o, conv_active_o, level_sel_o}, 16'h0);
        chk("point", {4'h0, point_addr_o}, 16'h0);
        $display("reset test done");
        cmd(PT, 16'h0005);
        bl(528);
        chk("converting", {15'h0, conv_active_o}, 16'h0);
        cmd(LV, 16'h085b);
        bl(96);
        chk("level", {13'h0, level_sel_o}, 16'h0);
        cmd(LV, 16'h085a);
        chk("level", {13'h0, level_sel_o}, 16'h2);
        cmd(LV, 16'h0859);
        chk("level", {13'h0, level_sel_o}, 16'h1);
        cmd(PT, 16'hf001);
        t0 = cyc;
        chk("point", {4'h0, point_addr_o}, 16'h1);
        cmd(LV, 16'h085a, 1'b1);
        chk("level", {13'h0, level_sel_o}, 16'h1);
        cmd(PT, 16'h0002);
        chk("point", {4'h0, point_addr_o}, 16'h1);
        while (cyc < t0 + CV - 3) wt(1);
        chk("irq early", {15'h0, irq_o}, 16'h0);
        wt(7);
        chk("irq", {15'h0, irq_o}, 16'h1);
        cmd(SA, 16'h0);
        chk("skip", q, 16'h0);
        cmd(AA, 16'h0);
        cmd(SA, 16'h0);
        chk("skip", q, 16'h1);
        fetch(16'h8004);
        chk("busy", {15'h0, busy_o}, 16'h0);
        cmd(XF, 16'h0480);
        cmd(RO, 16'h0003);
        chk("or read", q, 16'h8007);
        cmd(XF, 16'h0480);
        cmd(LV, 16'h0859);
        cmd(RC, 16'h0);
        chk("lost", q, 16'h0);
        cmd(PT, 16'h0000);
        for (int n = 0; n < CV + 8 && irq_o !== 1'b1; n++) wt(1);
        cmd(AA, 16'h0);
        fetch(16'h7ffc);
        $display("analog test done");
        cmd(XF, 16'h0842);
        bl(720);
        cmd(RC, 16'h0);
        chk("level card", q, 16'h0095);
        @(posedge clk_i) lvl <= 6'h2a;
        wt(8);
        chk("irq", {15'h0, irq_o}, 16'h0);
        dx(16'h0842, 16'h00aa);
        dx(16'h08a7, 16'h03f0);
        dx(16'h0857, 16'h05e8);
        cmd(XF, 16'h0858);
        chk("busy", {15'h0, busy_o}, 16'h0);
        cmd(XF, 16'h08c0);
        chk("busy", {15'h0, busy_o}, 16'h0);
        pl(3);
        dx(16'h0840, 16'h00ff);
        dx(16'h0840, 16'h003f);
        pl(31);
        chk("irq", {15'h0, irq_o}, 16'h0);
        pl(1);
        chk("irq", {15'h0, irq_o}, 16'h1);
        cmd(SC, 16'h0);
        chk("skip", q, 16'h0);
        cmd(AC, 16'h0);
        cmd(SC, 16'h0);
        chk("skip", q, 16'h1);
        dx(16'h0840, 16'h083f);
        @(posedge clk_i) alarm <= 6'h04;
        wt(6);
        chk("irq", {15'h0, irq_o}, 16'h1);
        cmd(SL, 16'h0);
        chk("skip", q, 16'h0);
        cmd(AL, 16'h0);
        cmd(SL, 16'h0);
        chk("skip", q, 16'h1);
        chk("irq", {15'h0, irq_o}, 16'h0);
        dx(16'h0841, 16'h013e);
        $display("digital test done");
        complete_run();
    end
endmodule
`default_nettype wire
